// file: rtl/triggered_profile_sequencer.sv
// profile sequencer: apb registers, section memory, trigger and loop control
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "tps_map.svh"
module triggered_profile_sequencer #(
	parameter int NUM_CHAN = 16,
	parameter int MAX_SECT = 100
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// logical channel values, signed
	input wire logic [NUM_CHAN-1:0][31:0] i_chan_val,
	// one-second time base and calendar
	input wire logic i_sec_tick,
	input wire tps_pkg::cal_t i_cal,
	// profile output
	output logic [31:0] o_profile_val,
	output logic o_running
);

	////////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [31:0] ctrl_r;
	logic [31:0] idle_r;
	logic [6:0] nsect_r;
	logic [6:0] retpos_r;
	logic [15:0] loopcnt_r;
	logic [31:0] month_r;
	logic [31:0] day_r;
	logic [31:0] wday_r;
	logic [31:0] hour_r;
	logic [31:0] min_lo_r;
	logic [31:0] min_hi_r;
	logic [31:0] sec_lo_r;
	logic [31:0] sec_hi_r;
	tps_pkg::section_t sect_mem [MAX_SECT];

	// sequencer state
	tps_pkg::state_t state_r, state_nxt;
	logic [6:0] idx_r, idx_nxt;
	logic [15:0] cyc_r, cyc_nxt;
	logic [27:0] elap_r, elap_nxt;
	logic [27:0] total_r, total_nxt;
	logic [31:0] start_r, start_nxt;
	logic [31:0] prev_r, prev_nxt;
	logic [31:0] out_nxt;
	logic trig_pos_d_r;
	logic div_start;
	logic [63:0] div_quot;
	logic div_done;

	////////////////////////////////////////////////////////////////////////////
	// apb decode

	wire logic setup = i_psel && !i_penable;
	wire logic wr_acc = i_psel && i_penable && o_pready && i_pwrite;
	wire logic [11:0] sect_off = i_paddr - `TPS_SECT_BASE;
	wire logic sect_hit = (i_paddr >= `TPS_SECT_BASE) && (i_paddr < `TPS_SECT_END);
	wire logic [6:0] sect_sel = sect_off[9:3];
	wire logic sect_w1 = sect_off[2];
	wire logic reg_hit = (i_paddr <= `TPS_REG_SEC_HI) || sect_hit;
	wire logic addr_ok = reg_hit && (i_paddr[1:0] == 2'h0);
	wire tps_pkg::section_t sect_rd = sect_mem[sect_sel];
	wire logic [31:0] sect_w0 = {11'h0, sect_rd.shape, 2'h0, sect_rd.unit, sect_rd.dur};
	wire logic [31:0] status = {cyc_r, 1'b0, idx_r, 7'h0, o_running};

	logic [31:0] rd_data;

	// read mux; reserved bits were masked at write time so they read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		if (sect_hit) begin
			rd_data = sect_w1 ? sect_rd.fin : sect_w0;
		end else begin
			unique case (i_paddr)
				`TPS_REG_CTRL: rd_data = ctrl_r;
				`TPS_REG_IDLE: rd_data = idle_r;
				`TPS_REG_NSECT: rd_data = {25'h0, nsect_r};
				`TPS_REG_RETPOS: rd_data = {25'h0, retpos_r};
				`TPS_REG_LOOPCNT: rd_data = {16'h0, loopcnt_r};
				`TPS_REG_STATUS: rd_data = status;
				`TPS_REG_OUTVAL: rd_data = o_profile_val;
				`TPS_REG_MONTH: rd_data = month_r;
				`TPS_REG_DAY: rd_data = day_r;
				`TPS_REG_WDAY: rd_data = wday_r;
				`TPS_REG_HOUR: rd_data = hour_r;
				`TPS_REG_MIN_LO: rd_data = min_lo_r;
				`TPS_REG_MIN_HI: rd_data = min_hi_r;
				`TPS_REG_SEC_LO: rd_data = sec_lo_r;
				`TPS_REG_SEC_HI: rd_data = sec_hi_r;
				default: rd_data = 32'h0000_0000;
			endcase
		end
	end

	// answer in the access cycle right after setup: one-cycle access phase
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= setup;
			o_prdata <= (setup && addr_ok && !i_pwrite) ? rd_data : 32'h0000_0000;
			o_pslverr <= setup && !addr_ok;
		end
	end

	// configuration writes
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ctrl_r <= 32'h0000_0000;
			idle_r <= 32'h0000_0000;
			nsect_r <= 7'h00;
			retpos_r <= 7'h00;
			loopcnt_r <= 16'h0000;
			month_r <= 32'h0000_0000;
			day_r <= 32'h0000_0000;
			wday_r <= 32'h0000_0000;
			hour_r <= 32'h0000_0000;
			min_lo_r <= 32'h0000_0000;
			min_hi_r <= 32'h0000_0000;
			sec_lo_r <= 32'h0000_0000;
			sec_hi_r <= 32'h0000_0000;
		end else if (wr_acc && addr_ok && !sect_hit) begin
			unique case (i_paddr)
				`TPS_REG_CTRL: ctrl_r <= i_pwdata & `TPS_CTRL_MASK;
				`TPS_REG_IDLE: idle_r <= i_pwdata;
				`TPS_REG_NSECT: nsect_r <= (i_pwdata > 32'(MAX_SECT)) ? 7'(MAX_SECT) : i_pwdata[6:0];
				`TPS_REG_RETPOS: retpos_r <= i_pwdata[6:0];
				`TPS_REG_LOOPCNT: loopcnt_r <= i_pwdata[15:0];
				`TPS_REG_MONTH: month_r <= i_pwdata & `TPS_MONTH_VALID;
				`TPS_REG_DAY: day_r <= i_pwdata & `TPS_DAY_VALID;
				`TPS_REG_WDAY: wday_r <= i_pwdata & `TPS_WDAY_VALID;
				`TPS_REG_HOUR: hour_r <= i_pwdata & `TPS_HOUR_VALID;
				`TPS_REG_MIN_LO: min_lo_r <= i_pwdata;
				`TPS_REG_MIN_HI: min_hi_r <= i_pwdata & `TPS_MIN_HI_VALID;
				`TPS_REG_SEC_LO: sec_lo_r <= i_pwdata;
				`TPS_REG_SEC_HI: sec_hi_r <= i_pwdata & `TPS_MIN_HI_VALID;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (wr_acc && addr_ok && sect_hit) begin
			if (sect_w1) begin
				sect_mem[sect_sel].fin <= i_pwdata;
			end else begin
				sect_mem[sect_sel].dur <= i_pwdata[`TPS_SECT_DUR];
				sect_mem[sect_sel].unit <= tps_pkg::unit_t'(i_pwdata[`TPS_SECT_UNIT]);
				sect_mem[sect_sel].shape <= tps_pkg::shape_t'(i_pwdata[`TPS_SECT_SHAPE]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// trigger and loop sources

	wire tps_pkg::trig_mode_t tmode = tps_pkg::trig_mode_t'(ctrl_r[`TPS_CTRL_TMODE]);
	wire tps_pkg::loop_mode_t lmode = tps_pkg::loop_mode_t'(ctrl_r[`TPS_CTRL_LMODE]);
	wire logic [3:0] tsrc = ctrl_r[`TPS_CTRL_TSRC];
	wire logic [3:0] lsrc = ctrl_r[`TPS_CTRL_LSRC];
	// channel select; an index past the last channel reads as zero
	wire logic [31:0] trig_val = (32'(tsrc) < 32'(NUM_CHAN)) ? i_chan_val[tsrc] : 32'h0000_0000;
	wire logic [31:0] lim_val = (32'(lsrc) < 32'(NUM_CHAN)) ? i_chan_val[lsrc] : 32'h0000_0000;
	wire logic trig_pos = !trig_val[31] && (trig_val != 32'h0000_0000);
	wire logic trig_rise = trig_pos && !trig_pos_d_r;
	wire logic running = (state_r != tps_pkg::S_IDLE);

	// one enable bit per calendar value; an empty field never matches
	wire logic [63:0] min_set = {min_hi_r, min_lo_r};
	wire logic [63:0] sec_set = {sec_hi_r, sec_lo_r};
	// all fields ANDed, sampled on the second tick
	wire logic cal_match = month_r[i_cal.month] && day_r[i_cal.day] && wday_r[i_cal.wday] &&
		hour_r[i_cal.hour] && min_set[i_cal.min] && sec_set[i_cal.sec];

	logic start_evt;
	logic abort_evt;

	// start and abort per trigger mode
	always_comb begin
		start_evt = 1'b0;
		abort_evt = 1'b0;
		unique case (tmode)
			// gate: start on the way up, drop to idle when it falls
			tps_pkg::TRIG_LEVEL: begin
				start_evt = trig_rise && !running;
				abort_evt = !trig_pos;
			end
			// single shot: later source changes are ignored
			tps_pkg::TRIG_ONCE: start_evt = trig_rise && !running;
			// retrigger restarts whatever the run state
			tps_pkg::TRIG_RETRIG: start_evt = trig_rise;
			// calendar start behaves as single shot
			tps_pkg::TRIG_TIME: start_evt = i_sec_tick && cal_match && !running;
			// disabled or unknown mode holds idle
			default: abort_evt = 1'b1;
		endcase
		if (nsect_r == 7'h00) begin
			start_evt = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// section arithmetic

	wire tps_pkg::section_t cur = sect_mem[idx_r];
	wire logic [11:0] unit_mult = (cur.unit == tps_pkg::UNIT_HOUR) ? `TPS_SEC_PER_HOUR :
		(cur.unit == tps_pkg::UNIT_MIN) ? `TPS_SEC_PER_MIN : 12'h001;
	wire logic [27:0] cur_total = 28'(cur.dur * unit_mult);
	wire logic [27:0] elap_inc = elap_r + 28'h000_0001;
	wire logic [32:0] diff = {cur.fin[31], cur.fin} - {start_r[31], start_r};
	wire logic [32:0] diff_mag = diff[32] ? 33'h0 - diff : diff;
	wire logic [63:0] div_num = 64'(diff_mag * elap_inc);
	wire logic [31:0] step = diff[32] ? 32'h0 - div_quot[31:0] : div_quot[31:0];
	wire logic [15:0] cyc_inc = cyc_r + 16'h0001;
	wire logic [6:0] ret_idx = (retpos_r < nsect_r) ? retpos_r : 7'h00;

	logic again;

	always_comb begin
		unique case (lmode)
			tps_pkg::LOOP_COUNT: again = cyc_inc < loopcnt_r;
			// stop once the count reaches the channel value
			tps_pkg::LOOP_CHAN: again = !lim_val[31] && (lim_val > {16'h0000, cyc_inc});
			tps_pkg::LOOP_INF: again = 1'b1;
			// looping off plays the list once
			default: again = 1'b0;
		endcase
	end

	// ramp value = start + diff * elapsed / total
	prof_divider #(
		.W(64)
	) u_div (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_start(div_start),
		.i_dividend(div_num),
		.i_divisor({36'h0, total_r}),
		.o_quot(div_quot),
		.o_done(div_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		logic sect_end;
		sect_end = 1'b0;
		state_nxt = state_r;
		idx_nxt = idx_r;
		cyc_nxt = cyc_r;
		elap_nxt = elap_r;
		total_nxt = total_r;
		start_nxt = start_r;
		prev_nxt = prev_r;
		out_nxt = o_profile_val;
		div_start = 1'b0;
		unique case (state_r)
			tps_pkg::S_IDLE: out_nxt = idle_r;
			tps_pkg::S_LOAD: begin
				start_nxt = prev_r;
				elap_nxt = 28'h000_0000;
				total_nxt = cur_total;
				// constant level is applied in the load cycle, well inside 0.1 s
				if (cur.shape == tps_pkg::SHAPE_CONST) begin
					out_nxt = cur.fin;
				end
				if (cur_total == 28'h000_0000) begin
					sect_end = 1'b1;
				end else begin
					state_nxt = tps_pkg::S_RUN;
				end
			end
			tps_pkg::S_RUN: begin
				if (i_sec_tick) begin
					elap_nxt = elap_inc;
					if (elap_inc >= total_r) begin
						out_nxt = cur.fin;
						sect_end = 1'b1;
					end else if (cur.shape == tps_pkg::SHAPE_RAMP) begin
						div_start = 1'b1;
						state_nxt = tps_pkg::S_DIV;
					end
				end
			end
			tps_pkg::S_DIV: begin
				if (div_done) begin
					out_nxt = start_r + step;
					state_nxt = tps_pkg::S_RUN;
				end
			end
			default: state_nxt = tps_pkg::S_IDLE;
		endcase
		// sections play in order, then the cycle ends
		if (sect_end) begin
			prev_nxt = cur.fin;
			state_nxt = tps_pkg::S_LOAD;
			if (idx_r + 7'h01 < nsect_r) begin
				idx_nxt = idx_r + 7'h01;
			end else begin
				cyc_nxt = cyc_inc;
				// repetitions resume at the return section
				if (again) begin
					idx_nxt = ret_idx;
				end else begin
					state_nxt = tps_pkg::S_IDLE;
					out_nxt = idle_r;
				end
			end
		end
		if (abort_evt) begin
			state_nxt = tps_pkg::S_IDLE;
			out_nxt = idle_r;
		end
		// new start clears the cycle count; first ramp leaves idle value
		if (start_evt) begin
			state_nxt = tps_pkg::S_LOAD;
			idx_nxt = 7'h00;
			cyc_nxt = 16'h0000;
			prev_nxt = idle_r;
		end
	end

	// state registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_r <= tps_pkg::S_IDLE;
			idx_r <= 7'h00;
			cyc_r <= 16'h0000;
			elap_r <= 28'h000_0000;
			total_r <= 28'h000_0000;
			start_r <= 32'h0000_0000;
			prev_r <= 32'h0000_0000;
			o_profile_val <= 32'h0000_0000;
			o_running <= 1'b0;
			trig_pos_d_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			cyc_r <= cyc_nxt;
			elap_r <= elap_nxt;
			total_r <= total_nxt;
			start_r <= start_nxt;
			prev_r <= prev_nxt;
			o_profile_val <= out_nxt;
			o_running <= (state_nxt != tps_pkg::S_IDLE);
			trig_pos_d_r <= trig_pos;
		end
	end

endmodule : triggered_profile_sequencer

// file: common/tps_map.svh
// register map, field positions and timing constants of the triggered profile sequencer
//
// Functional notes
// - level-gate mode: waveform runs only while trigger source is above zero.
// - single-shot mode: rising edge starts a run that always completes.
// - retrigger mode: every rising edge restarts from the first section.
// - trigger source is one channel picked by a configuration index.
// - output equals idle value whenever no waveform is running.
// - up to 100 sections of duration, unit, shape, final value, played in order.
// - looping off: section list played once per trigger, then idle.
// - counted looping: waveform played loop-count times, once when the count is zero.
// - channel looping: completed cycles compared with a selected channel value.
// - infinite looping: waveform repeats forever once started.
// - with looping, repetitions after the first begin at the return section.
// - time mode: start on calendar match with one-second resolution.
// - each calendar field is a set of enable bits, one per value.
// - a calendar field with no bit set means no time start at all.
// - a time start behaves as single-shot: the run always completes.
// - ramp moves linearly from previous final value to its own final value.
// - resuming at a constant section jumps to its level within 0.1 s.
// - section duration unit is seconds, minutes or hours.
// - channel looping stops once completed cycles reach the channel value.
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH

// register byte offsets
`define TPS_REG_CTRL 12'h000
`define TPS_REG_IDLE 12'h004
`define TPS_REG_NSECT 12'h008
`define TPS_REG_RETPOS 12'h00c
`define TPS_REG_LOOPCNT 12'h010
`define TPS_REG_STATUS 12'h014
`define TPS_REG_OUTVAL 12'h018
`define TPS_REG_MONTH 12'h01c
`define TPS_REG_DAY 12'h020
`define TPS_REG_WDAY 12'h024
`define TPS_REG_HOUR 12'h028
`define TPS_REG_MIN_LO 12'h02c
`define TPS_REG_MIN_HI 12'h030
`define TPS_REG_SEC_LO 12'h034
`define TPS_REG_SEC_HI 12'h038
`define TPS_SECT_BASE 12'h400
`define TPS_SECT_END 12'h720

// control fields
`define TPS_CTRL_TMODE 2:0
`define TPS_CTRL_LMODE 5:4
`define TPS_CTRL_TSRC 11:8
`define TPS_CTRL_LSRC 15:12
`define TPS_CTRL_MASK 32'h0000_ff37
// section word 0 fields
`define TPS_SECT_DUR 15:0
`define TPS_SECT_UNIT 17:16
`define TPS_SECT_SHAPE 20
// status fields
`define TPS_STAT_RUN 0
`define TPS_STAT_IDX 14:8
`define TPS_STAT_CYC 31:16

// valid bits of the calendar masks (bit n enables value n)
`define TPS_MONTH_VALID 32'h0000_1ffe
`define TPS_DAY_VALID 32'hffff_fffe
`define TPS_WDAY_VALID 32'h0000_007f
`define TPS_HOUR_VALID 32'h00ff_ffff
`define TPS_MIN_HI_VALID 32'h0fff_ffff

// duration units in seconds
`define TPS_SEC_PER_MIN 12'h03c
`define TPS_SEC_PER_HOUR 12'he10

`endif

// file: common/tps_pkg.sv
// types shared by the triggered profile sequencer
package tps_pkg;

	typedef enum logic [2:0] {
		TRIG_DIS = 3'h0,
		TRIG_LEVEL = 3'h1,
		TRIG_ONCE = 3'h2,
		TRIG_RETRIG = 3'h3,
		TRIG_TIME = 3'h4
	} trig_mode_t;

	typedef enum logic [1:0] {
		LOOP_OFF = 2'h0,
		LOOP_COUNT = 2'h1,
		LOOP_CHAN = 2'h2,
		LOOP_INF = 2'h3
	} loop_mode_t;

	typedef enum logic [1:0] {
		UNIT_SEC = 2'h0,
		UNIT_MIN = 2'h1,
		UNIT_HOUR = 2'h2
	} unit_t;

	typedef enum logic {
		SHAPE_CONST = 1'b0,
		SHAPE_RAMP = 1'b1
	} shape_t;

	typedef struct packed {
		logic [15:0] dur;
		unit_t unit;
		shape_t shape;
		logic [31:0] fin;
	} section_t;

	typedef struct packed {
		logic [3:0] month;
		logic [4:0] day;
		logic [2:0] wday;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} cal_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_LOAD = 4'h2,
		S_RUN = 4'h4,
		S_DIV = 4'h8
	} state_t;

endpackage : tps_pkg

// file: rtl/prof_divider.sv
// serial unsigned restoring divider used for ramp interpolation
`timescale 1ns/1ps
module prof_divider #(
	parameter int W = 64
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// request
	input wire logic i_start,
	input wire logic [W-1:0] i_dividend,
	input wire logic [W-1:0] i_divisor,
	// answer
	output logic [W-1:0] o_quot,
	output logic o_done
);
	localparam int CW = $clog2(W + 1);

	logic [W-1:0] rem_r;
	logic [W-1:0] dvs_r;
	logic [CW-1:0] cnt_r;
	logic busy_r;

	// one quotient bit per clock; divisor stays small so remainder never overflows
	wire logic [W-1:0] rem_shift = {rem_r[W-2:0], o_quot[W-1]};
	wire logic sub_ok = rem_shift >= dvs_r;
	wire logic last = busy_r && (cnt_r == CW'(1));

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_quot <= '0;
			rem_r <= '0;
			dvs_r <= '0;
			cnt_r <= '0;
			busy_r <= 1'b0;
			o_done <= 1'b0;
		end else if (i_start) begin
			o_quot <= i_dividend;
			rem_r <= '0;
			dvs_r <= i_divisor;
			cnt_r <= CW'(W);
			busy_r <= 1'b1;
			o_done <= 1'b0;
		end else begin
			if (busy_r) begin
				rem_r <= sub_ok ? rem_shift - dvs_r : rem_shift;
				o_quot <= {o_quot[W-2:0], sub_ok};
				cnt_r <= cnt_r - CW'(1);
			end
			busy_r <= busy_r && !last;
			o_done <= last;
		end
	end

endmodule : prof_divider

// file: verif/tps_props.sv
// port checker of the profile sequencer
`timescale 1ns/1ps
`include "tps_map.svh"
module tps_props #(
	parameter int NUM_CHAN = 16
) (
	// clock, reset, apb
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// channels, time base, output
	input wire logic [NUM_CHAN-1:0][31:0] i_chan_val,
	input wire logic i_sec_tick,
	input wire tps_pkg::cal_t i_cal,
	input wire logic [31:0] o_profile_val,
	input wire logic o_running
);
	logic [15:0] ctrl_r;
	logic [31:0] idle_r;
	logic [6:0] nsect_r;
	logic [12:0] month_r;
	// shadows of the written configuration, taken at the same edge as the design
	wire wr = i_psel && i_penable && o_pready && i_pwrite;
	wire signed [31:0] src = i_chan_val[ctrl_r[11:8]];
	wire [2:0] tm = ctrl_r[2:0];
	wire dis = tm == 3'h0 || tm > 3'h4;
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ctrl_r <= 16'h0000;
			idle_r <= 32'h0000_0000;
			nsect_r <= 7'h00;
			month_r <= 13'h0000;
		end else if (wr) begin
			case (i_paddr)
				`TPS_REG_CTRL: ctrl_r <= i_pwdata[15:0];
				`TPS_REG_IDLE: idle_r <= i_pwdata;
				`TPS_REG_NSECT: nsect_r <= i_pwdata[6:0];
				`TPS_REG_MONTH: month_r <= i_pwdata[12:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// one wait-free access cycle after every setup
	apb_ready_a: assert property (i_psel && !i_penable |=> o_pready) else $error("no ready after setup");
	ready_in_access_a: assert property (o_pready |-> i_psel && i_penable) else $error("ready outside access");
	// holes in the map answer with an error and zero data
	unmapped_err_a: assert property (i_psel && !i_penable && i_paddr > 12'h038 && i_paddr < 12'h400
		|=> o_pslverr && o_prdata == 32'h0000_0000) else $error("hole answered without error");
	idle_out_a: assert property ((!o_running) [*3] ##0 $stable(idle_r) |-> o_profile_val == idle_r)
		else $error("output differs from idle value");
	dis_idle_a: assert property (dis [*3] |-> !o_running) else $error("running while disabled");
	gate_low_a: assert property ((tm == 3'h1 && src <= 0) [*3] |-> !o_running)
		else $error("running with gate low");
	// edge on the selected channel starts a run
	edge_start_a: assert property (tm inside {3'h1, 3'h2, 3'h3} && nsect_r != 7'h00 && !o_running
		&& $past(src) <= 0 && src > 0 |=> o_running) else $error("edge did not start");
	empty_set_a: assert property (tm == 3'h4 && month_r == 13'h0000 && !o_running |=> !o_running)
		else $error("time start with empty set");
endmodule : tps_props
bind triggered_profile_sequencer tps_props #(.NUM_CHAN(NUM_CHAN)) u_props (.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_chan_val(i_chan_val), .i_sec_tick(i_sec_tick), .i_cal(i_cal), .o_profile_val(o_profile_val),
	.o_running(o_running));

// file: verif/chan_model.sv
// model of the logical channels, second time base and calendar
`timescale 1ns/1ps
module chan_model #(
	parameter int NUM_CHAN = 16,
	parameter int TRIG_IDX = 3,
	parameter int LIM_IDX = 5,
	parameter int TICK_GAP = 80
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// values commanded by the bench
	input wire logic [31:0] i_trig,
	input wire logic [31:0] i_limit,
	// channels, time base, calendar
	output logic [NUM_CHAN-1:0][31:0] o_chan_val,
	output logic o_sec_tick,
	output tps_pkg::cal_t o_cal
);
	int gap_r;
	// other channels carry the inverse so a wrong pick is seen
	always_comb begin
		for (int k = 0; k < NUM_CHAN; k++) begin
			o_chan_val[k] = ~i_trig;
		end
		o_chan_val[TRIG_IDX] = i_trig;
		o_chan_val[LIM_IDX] = i_limit;
	end
	// ticks stay far apart so the ramp divider never swallows one
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			gap_r <= 0;
			o_sec_tick <= 1'b0;
			o_cal <= {4'h3, 5'h07, 3'h2, 5'h0a, 6'h00, 6'h00};
		end else begin
			gap_r <= (gap_r == TICK_GAP - 1) ? 0 : gap_r + 1;
			o_sec_tick <= gap_r == TICK_GAP - 1;
			if (o_sec_tick) o_cal.sec <= (o_cal.sec == 6'h3b) ? 6'h00 : o_cal.sec + 6'h01;
		end
	end
endmodule : chan_model

// file: verif/triggered_profile_sequencer_tb.sv
// self-checking bench of the profile sequencer
`timescale 1ns/1ps
`include "tps_map.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module triggered_profile_sequencer_tb;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, tick, running, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, val, trig, limit, rd, seed, a, b, idle;
	logic [15:0][31:0] chan;
	tps_pkg::cal_t cal;
	int mismatches, comparisons, n, v;
	triggered_profile_sequencer #(.NUM_CHAN(16), .MAX_SECT(100)) u_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_chan_val(chan), .i_sec_tick(tick),
		.i_cal(cal), .o_profile_val(val), .o_running(running));
	chan_model #(.NUM_CHAN(16)) u_chan (.i_clk_sys(clk), .i_rst_n(rst_n), .i_trig(trig), .i_limit(limit),
		.o_chan_val(chan), .o_sec_tick(tick), .o_cal(cal));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// narrow signed values keep the ramp product inside 64 bits
	function automatic logic [31:0] r20();
		logic [31:0] x;
		x = xs();
		return {{12{x[19]}}, x[19:0]};
	endfunction : r20
	// division truncates toward zero, which is toward the start value
	function automatic logic [31:0] ramp_exp(input logic signed [31:0] s, input logic signed [31:0] f,
		input int e, input int t);
		longint d;
		d = (longint'(f) - longint'(s)) * e / t;
		return s + 32'(d);
	endfunction : ramp_exp
	// waits for ready as long as it takes; only the watchdog ends a hung access
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic ticks(input int k);
		repeat (k) @(posedge clk iff tick);
	endtask : ticks
	// raise the trigger just after a tick so loads never meet one
	task automatic fire();
		@(posedge clk iff tick);
		trig <= 32'h0000_0001;
	endtask : fire
	// a run that never ends is left to the watchdog
	task automatic run_ticks(output int k);
		k = 0;
		while (running !== 1'b0) begin
			@(posedge clk);
			if (tick && running) k++;
		end
	endtask : run_ticks
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// watchdog well past the expected run of about 9100 cycles
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		close_out();
	end
	initial begin
		seed = 32'h0000_702a;
		{rst_n, psel, penable, pwrite, paddr, pwdata, trig, limit} = '0;
		mismatches = 0;
		comparisons = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		`CHK(val, 32'h0000_0000)
		apb(1'b0, 12'h03c, 32'h0);
		`CHK({err, rd}, 33'h1_0000_0000)
		a = r20();
		b = r20();
		idle = r20();
		apb(1'b1, `TPS_REG_IDLE, idle);
		apb(1'b1, `TPS_REG_STATUS, 32'hffff_ffff);
		apb(1'b0, `TPS_REG_STATUS, 32'h0);
		`CHK(rd, 32'h0000_0000)
		// const section then ramp section, two seconds each
		apb(1'b1, 12'h400, 32'h0000_0002);
		apb(1'b1, 12'h404, a);
		apb(1'b1, 12'h408, 32'h0010_0002);
		apb(1'b1, 12'h40c, b);
		apb(1'b1, `TPS_REG_NSECT, 32'h0000_0002);
		apb(1'b1, `TPS_REG_RETPOS, 32'h0000_0001);
		`CHK(val, idle)
		// single shot survives the source dropping
		apb(1'b1, `TPS_REG_CTRL, 32'h0000_0302);
		fire();
		repeat (4) @(posedge clk);
		`CHK(val, a)
		trig <= 32'h0;
		ticks(3);
		repeat (75) @(posedge clk);
		`CHK(val, ramp_exp(a, b, 1, 2))
		`CHK(running, 1'b1)
		ticks(1);
		repeat (5) @(posedge clk);
		`CHK({running, val}, {1'b0, idle})
		// a new edge mid-section restarts at section zero
		apb(1'b1, `TPS_REG_CTRL, 32'h0000_0303);
		fire();
		ticks(1);
		trig <= 32'h0;
		@(posedge clk);
		trig <= 32'h0000_0001;
		ticks(1);
		repeat (5) @(posedge clk);
		apb(1'b0, `TPS_REG_STATUS, 32'h0);
		`CHK(rd[14:8], 7'h00)
		apb(1'b1, `TPS_REG_CTRL, 32'h0);
		trig <= 32'h0;
		repeat (3) @(posedge clk);
		`CHK({running, val}, {1'b0, idle})
		apb(1'b1, `TPS_REG_CTRL, 32'h0000_0301);
		trig <= 32'h0000_0001;
		repeat (4) @(posedge clk);
		`CHK(running, 1'b1)
		trig <= 32'h0;
		repeat (3) @(posedge clk);
		`CHK(running, 1'b0)
		// counted and channel loops, repeats from section one
		for (int i = 0; i < 4; i++) begin
			v = int'(xs() % 4);
			limit <= 32'(v);
			apb(1'b1, `TPS_REG_LOOPCNT, 32'(v));
			apb(1'b1, `TPS_REG_CTRL, i[0] ? 32'h0000_5322 : 32'h0000_5312);
			fire();
			@(posedge clk);
			trig <= 32'h0;
			repeat (3) @(posedge clk);
			run_ticks(n);
			`CHK(n, 2 + 2 * ((v < 1) ? 1 : v))
		end
		// endless loop until disabled; repeats now resume at the constant section
		apb(1'b1, `TPS_REG_RETPOS, 32'h0000_0000);
		apb(1'b1, `TPS_REG_CTRL, 32'h0000_5332);
		fire();
		@(posedge clk);
		trig <= 32'h0;
		ticks(12);
		repeat (3) @(posedge clk);
		`CHK(val, a)
		`CHK(running, 1'b1)
		apb(1'b1, `TPS_REG_CTRL, 32'h0);
		repeat (3) @(posedge clk);
		`CHK(running, 1'b0)
		// section zero now lasts one minute for the calendar run
		apb(1'b1, 12'h400, 32'h0001_0001);
		// empty sets, then one field missing, then a full match
		apb(1'b1, `TPS_REG_CTRL, 32'h0000_0004);
		ticks(3);
		`CHK(running, 1'b0)
		// hour stays narrow while the other fields fill, so no tick can match in between
		for (int ad = 'h01c; ad <= 'h038; ad += 4) begin
			apb(1'b1, 12'(ad), (12'(ad) == `TPS_REG_HOUR) ? 32'h0000_0001 : 32'hffff_ffff);
		end
		ticks(3);
		`CHK(running, 1'b0)
		apb(1'b1, `TPS_REG_HOUR, 32'h00ff_ffff);
		ticks(1);
		repeat (4) @(posedge clk);
		`CHK(running, 1'b1)
		// every tick still matches, yet the run must end after one minute and two seconds
		run_ticks(n);
		`CHK(n, 62)
		close_out();
	end
endmodule : triggered_profile_sequencer_tb
